// file: design/aems_pkg.sv
package aems_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [11:0] UNC_STATUS_OFS = 12'h104;
  localparam logic [11:0] UNC_MASK_OFS = 12'h108;
  localparam logic [11:0] UNC_SEV_OFS = 12'h10c;
  localparam logic [11:0] COR_STATUS_OFS = 12'h110;
  localparam logic [11:0] COR_MASK_OFS = 12'h114;
  localparam logic [11:0] ERR_CTRL_OFS = 12'h118;
  localparam logic [11:0] HDR_LOG_OFS = 12'h11c;
  localparam int HDR_DWORDS = 4;

  // ------------------------------------------------------------
  // Field layouts and reset values
  // ------------------------------------------------------------
  // Implemented uncorrectable bits: 0, 4, 12..21
  localparam logic [31:0] UNC_IMPL = 32'h003f_f011;
  localparam logic [31:0] UNC_MASK_RST = 32'h0000_0000;
  // Fatal by default: training, link protocol, flow control, overflow, malformed
  localparam logic [31:0] UNC_SEV_RST = 32'h0006_2011;
  // Implemented correctable bits: 0, 6, 7, 8, 12, 13
  localparam logic [31:0] COR_IMPL = 32'h0000_31c1;
  localparam logic [31:0] COR_MASK_RST = 32'h0000_2000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam int FEP_W = 5;
  localparam logic [FEP_W-1:0] FEP_RST = 5'h00;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0] unc;             // One-cycle uncorrectable event pulses
    logic [31:0] cor;             // One-cycle correctable event pulses
    logic [HDR_DWORDS-1:0][31:0] hdr; // Header of the offending packet
  } aems_evt_t;

  typedef struct packed {
    logic valid;
    logic fatal;
    logic nonfatal;
    logic cor;
  } aems_msg_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } aems_bus_t;

endpackage

// file: design/aems_regs.sv
`timescale 1ns/100ps

import aems_pkg::*;

module aems_regs (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic hot_reset,
  input wire aems_pkg::aems_bus_t bus,
  output logic [31:0] rdata,
  input wire aems_pkg::aems_evt_t evt,
  output aems_pkg::aems_msg_t msg,
  output logic hdr_logged
);
  import aems_pkg::*;

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  // Power-on reset is asserted at once, released through two flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [31:0] unc_status;
  logic [31:0] unc_mask;
  logic [31:0] unc_sev;
  logic [31:0] cor_status;
  logic [31:0] cor_mask;
  logic [FEP_W-1:0] fep;
  logic log_held;
  logic [HDR_DWORDS-1:0][31:0] hdr_log;

  logic [31:0] unc_ev;
  logic [31:0] cor_ev;
  logic [31:0] unc_rep;
  logic [31:0] cor_rep;
  logic any_fatal;
  logic any_nonfatal;
  logic capture;
  logic wr_unc_status;
  logic wr_cor_status;

  // Lowest set bit of a vector, used for both pointer update and its check
  function automatic logic [FEP_W-1:0] first_bit(input logic [31:0] v);
    logic [FEP_W-1:0] idx;
    idx = FEP_RST;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        idx = FEP_W'(i);
      end
    end
    return idx;
  endfunction

  // Address match for a write strobe, used by every writable register
  function automatic logic wr_hit(input aems_bus_t b, input logic [11:0] ofs);
    return b.wr && (b.addr == ofs);
  endfunction

  // ------------------------------------------------------------
  // Event qualification
  // ------------------------------------------------------------
  // Events on reserved positions are dropped here so they never reach state
  assign unc_ev = evt.unc & UNC_IMPL;
  assign cor_ev = evt.cor & COR_IMPL;
  assign unc_rep = unc_ev & ~unc_mask;
  assign cor_rep = cor_ev & ~cor_mask;
  assign any_fatal = |(unc_rep & unc_sev);
  assign any_nonfatal = |(unc_rep & ~unc_sev);
  // Log only when no earlier uncorrectable header is still held
  assign capture = (|unc_rep) && !log_held;
  assign wr_unc_status = wr_hit(bus, UNC_STATUS_OFS);
  assign wr_cor_status = wr_hit(bus, COR_STATUS_OFS);

  // ------------------------------------------------------------
  // Sticky configuration: survive hot reset, cleared only by power-on
  // ------------------------------------------------------------
  // sticky masks and severity
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      unc_mask <= UNC_MASK_RST;
      unc_sev <= UNC_SEV_RST;
      cor_mask <= COR_MASK_RST;
    end else begin
      if (wr_hit(bus, UNC_MASK_OFS)) begin
        unc_mask <= bus.wdata & UNC_IMPL;
      end
      if (wr_hit(bus, UNC_SEV_OFS)) begin
        unc_sev <= bus.wdata & UNC_IMPL;
      end
      // advisory mask written like the rest after reset
      if (wr_hit(bus, COR_MASK_OFS)) begin
        cor_mask <= bus.wdata & COR_IMPL;
      end
    end
  end

  // ------------------------------------------------------------
  // Sticky status flags
  // ------------------------------------------------------------
  // set from raw events, set wins over clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      unc_status <= ZERO_WORD;
    end else if (wr_unc_status) begin
      unc_status <= (unc_status & ~bus.wdata) | unc_ev;
    end else begin
      unc_status <= unc_status | unc_ev;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cor_status <= ZERO_WORD;
    end else if (wr_cor_status) begin
      cor_status <= (cor_status & ~bus.wdata) | cor_ev;
    end else begin
      cor_status <= cor_status | cor_ev;
    end
  end

  // ------------------------------------------------------------
  // First error pointer and header log
  // ------------------------------------------------------------
  // pointer frozen until its status bit is cleared
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fep <= FEP_RST;
      log_held <= 1'b0;
    end else if (capture) begin
      fep <= first_bit(unc_rep);
      log_held <= 1'b1;
    end else if (wr_unc_status && bus.wdata[fep] && !unc_ev[fep]) begin
      // Clearing the flagged error frees the log for the next one
      log_held <= 1'b0;
    end
  end

  // header kept in arrival byte order
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hdr_log <= '0;
    end else if (capture) begin
      hdr_log <= evt.hdr;
    end
  end

  // ------------------------------------------------------------
  // Error message and log indication
  // ------------------------------------------------------------
  // Non-sticky: a hot reset drops any pending message
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      msg <= '0;
      hdr_logged <= 1'b0;
    end else if (hot_reset) begin
      msg <= '0;
      hdr_logged <= 1'b0;
    end else begin
      // Fatal outranks non-fatal outranks correctable in one message
      msg.valid <= any_fatal || any_nonfatal || (|cor_rep);
      msg.fatal <= any_fatal;
      msg.nonfatal <= !any_fatal && any_nonfatal;
      msg.cor <= !any_fatal && !any_nonfatal && (|cor_rep);
      hdr_logged <= capture;
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  // Data stands one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= ZERO_WORD;
    end else if (bus.rd) begin
      unique case (bus.addr)
        UNC_STATUS_OFS: rdata <= unc_status;
        UNC_MASK_OFS: rdata <= unc_mask;
        UNC_SEV_OFS: rdata <= unc_sev;
        COR_STATUS_OFS: rdata <= cor_status;
        COR_MASK_OFS: rdata <= cor_mask;
        ERR_CTRL_OFS: rdata <= {{(32-FEP_W){1'b0}}, fep};
        HDR_LOG_OFS: rdata <= hdr_log[0];
        HDR_LOG_OFS + 12'h004: rdata <= hdr_log[1];
        HDR_LOG_OFS + 12'h008: rdata <= hdr_log[2];
        HDR_LOG_OFS + 12'h00c: rdata <= hdr_log[3];
        default: rdata <= ZERO_WORD;
      endcase
    end else begin
      rdata <= ZERO_WORD;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  masked_silent_a: assert property (
    (unc_rep == ZERO_WORD) && (cor_rep == ZERO_WORD) |=> !msg.valid)
    else $error("masked error produced a message");

  unmasked_sent_a: assert property (
    (cor_ev & ~cor_mask) != ZERO_WORD && !hot_reset |=> msg.valid)
    else $error("unmasked correctable error not reported");

  unc_flag_set_a: assert property (
    unc_ev != ZERO_WORD |=> (unc_status & $past(unc_ev)) == $past(unc_ev))
    else $error("uncorrectable flag not set by event");

  cor_flag_set_a: assert property (
    cor_ev != ZERO_WORD |=> (cor_status & $past(cor_ev)) == $past(cor_ev))
    else $error("correctable flag not set by event");

  cor_clear_a: assert property (
    wr_cor_status && cor_ev == ZERO_WORD
      |=> cor_status == ($past(cor_status) & ~$past(bus.wdata)))
    else $error("correctable write-one-clear wrong");

  sev_fatal_a: assert property (
    (unc_rep & unc_sev) != ZERO_WORD && !hot_reset |=> msg.fatal && !msg.nonfatal)
    else $error("fatal severity not honoured");

  sev_nonfatal_a: assert property (
    unc_rep != ZERO_WORD && (unc_rep & unc_sev) == ZERO_WORD && !hot_reset
      |=> msg.nonfatal && !msg.fatal)
    else $error("non-fatal severity not honoured");

  hdr_capture_a: assert property (
    capture |=> hdr_log == $past(evt.hdr) ##1 hdr_log == $past(evt.hdr, 2) || $past(capture))
    else $error("header log not captured");

  fep_first_a: assert property (
    capture |=> fep == first_bit($past(unc_rep)) && log_held)
    else $error("first error pointer wrong");

  sticky_hot_a: assert property (
    hot_reset && !bus.wr |=> $stable(unc_mask) && $stable(cor_mask) && $stable(unc_sev))
    else $error("sticky bits disturbed by hot reset");

  reserved_zero_a: assert property (
    (unc_mask & ~UNC_IMPL) == ZERO_WORD && (cor_status & ~COR_IMPL) == ZERO_WORD)
    else $error("reserved bits set");

  // ------------------------------------------------------------
  // Checks on logging, register writes and message classes
  // ------------------------------------------------------------
  // One class per message, so the sink never has to untangle a mixed report
  msg_class_a: assert property (
    msg.valid |-> $onehot({msg.fatal, msg.nonfatal, msg.cor}))
    else $error("message class not unique");

  msg_quiet_a: assert property (
    !msg.valid |-> !msg.fatal && !msg.nonfatal && !msg.cor)
    else $error("message class without valid");

  unc_sent_a: assert property (
    unc_rep != ZERO_WORD && !hot_reset |=> msg.valid && !msg.cor)
    else $error("unmasked uncorrectable error not reported");

  cor_only_a: assert property (
    unc_rep == ZERO_WORD && cor_rep != ZERO_WORD && !hot_reset |=> msg.cor)
    else $error("correctable class not chosen");

  hot_quiet_a: assert property (
    hot_reset |=> !msg.valid && !hdr_logged)
    else $error("message left standing after hot reset");

  log_masked_a: assert property (
    unc_rep == ZERO_WORD |=> !hdr_logged)
    else $error("masked error logged a header");

  log_untouched_a: assert property (
    unc_rep == ZERO_WORD |=> $stable(fep) && $stable(hdr_log))
    else $error("log changed without an unmasked error");

  log_frozen_a: assert property (
    log_held |=> $stable(fep) && $stable(hdr_log))
    else $error("held log overwritten");

  log_taken_a: assert property (
    unc_rep != ZERO_WORD && !log_held && !hot_reset |=> hdr_logged && msg.valid)
    else $error("free log not filled");

  logged_msg_a: assert property (
    hdr_logged |-> msg.valid && !msg.cor)
    else $error("header logged without a message");

  unc_clear_a: assert property (
    wr_unc_status && unc_ev == ZERO_WORD
      |=> unc_status == ($past(unc_status) & ~$past(bus.wdata)))
    else $error("uncorrectable write-one-clear wrong");

  mask_write_a: assert property (
    wr_hit(bus, UNC_MASK_OFS) |=> unc_mask == ($past(bus.wdata) & UNC_IMPL))
    else $error("uncorrectable mask write lost");

  sev_write_a: assert property (
    wr_hit(bus, UNC_SEV_OFS) |=> unc_sev == ($past(bus.wdata) & UNC_IMPL))
    else $error("severity write lost");

  cor_mask_write_a: assert property (
    wr_hit(bus, COR_MASK_OFS) |=> cor_mask == ($past(bus.wdata) & COR_IMPL))
    else $error("correctable mask write lost");

  rsvd_cfg_a: assert property (
    (unc_sev & ~UNC_IMPL) == ZERO_WORD && (cor_mask & ~COR_IMPL) == ZERO_WORD
      && (unc_status & ~UNC_IMPL) == ZERO_WORD)
    else $error("reserved config bits set");

endmodule

// file: sim/aems_rc_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Root complex error message sink
// ------------------------------------------------------------
module aems_rc_model
  import aems_pkg::*;
(
  input wire logic core_clk,
  input wire aems_pkg::aems_msg_t msg
);
  int n_msg = 0;
  // Tally every message; the sink never stalls, as a real one does not
  always @(posedge core_clk) begin
    if (msg.valid === 1'b1) begin
      n_msg <= n_msg + 1;
    end
  end
endmodule

// file: sim/aems_regs_tb.sv
`timescale 1ns/100ps
module aems_regs_tb;
  import aems_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic hot_reset = 1'b0;
  aems_bus_t bus = '0;
  aems_evt_t evt = '0;
  logic [31:0] rdata;
  aems_msg_t msg;
  logic hdr_logged;
  int err_count = 0;
  int checks_done = 0;
  int exp_msgs = 0;
  logic [31:0] rd_val;
  logic [31:0] sev = 32'h0039_d000;
  int unc_bits[12] = '{0, 4, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21};
  int cor_bits[6] = '{0, 6, 7, 8, 12, 13};

  // Free-running 10 MHz clock
  initial begin
    forever #50 core_clk = ~core_clk;
  end

  aems_regs dut (.core_clk(core_clk), .arst_n(arst_n), .hot_reset(hot_reset), .bus(bus),
    .rdata(rdata), .evt(evt), .msg(msg), .hdr_logged(hdr_logged));
  aems_rc_model rc (.core_clk(core_clk), .msg(msg));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic reg_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1 rd_val = rdata;
    chk(what, exp, rd_val);
  endtask

  // One-cycle event pulse; returns inside the cycle where the message stands
  task automatic fire(input logic [31:0] u, input logic [31:0] c);
    @(posedge core_clk);
    evt.unc <= u;
    evt.cor <= c;
    @(posedge core_clk);
    evt.unc <= 32'h0000_0000;
    evt.cor <= 32'h0000_0000;
    #1;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset_values();
    reg_chk("unc_mask", UNC_MASK_OFS, 32'h0000_0000);
    reg_chk("unc_sev", UNC_SEV_OFS, 32'h0006_2011);
    reg_chk("cor_status", COR_STATUS_OFS, 32'h0000_0000);
    reg_chk("cor_mask", COR_MASK_OFS, 32'h0000_2000);
    reg_chk("unmapped", 12'h200, 32'h0000_0000);
    $display("test reset_values done");
  endtask

  // Reserved bits read zero; sticky values outlive a hot reset
  task automatic t_fields_sticky();
    reg_wr(UNC_MASK_OFS, 32'hffff_ffff);
    reg_chk("unc_mask_rsvd", UNC_MASK_OFS, 32'h003f_f011);
    reg_wr(COR_MASK_OFS, 32'hffff_ffff);
    reg_chk("cor_mask_rsvd", COR_MASK_OFS, 32'h0000_31c1);
    reg_wr(UNC_SEV_OFS, sev);
    @(posedge core_clk);
    hot_reset <= 1'b1;
    @(posedge core_clk);
    hot_reset <= 1'b0;
    reg_chk("mask_after_hot", UNC_MASK_OFS, 32'h003f_f011);
    reg_chk("sev_after_hot", UNC_SEV_OFS, sev);
    $display("test fields_sticky done");
  endtask

  // Masked uncorrectable events: flag set, nothing reported or logged
  task automatic t_unc_masked();
    logic [31:0] bv;
    foreach (unc_bits[i]) begin
      bv = 32'h0000_0001 << unc_bits[i];
      fire(bv, 32'h0000_0000);
      chk("msg_valid_masked", 32'h0000_0000, 32'(msg.valid));
      chk("log_masked", 32'h0000_0000, 32'(hdr_logged));
      reg_chk("unc_status_masked", UNC_STATUS_OFS, bv);
      reg_wr(UNC_STATUS_OFS, bv);
      reg_chk("unc_status_clr", UNC_STATUS_OFS, 32'h0000_0000);
    end
    $display("test unc_masked done");
  endtask

  task automatic t_unc_report();
    logic [31:0] bv;
    reg_wr(UNC_MASK_OFS, 32'h0000_0000);
    foreach (unc_bits[i]) begin
      bv = 32'h0000_0001 << unc_bits[i];
      // A fresh header per event, so a stale log cannot pass
      for (int k = 0; k < HDR_DWORDS; k++) begin
        evt.hdr[k] <= 32'h0a0b_0c00 + 32'(16 * i + k);
      end
      fire(bv, 32'h0000_0000);
      exp_msgs++;
      chk("msg_valid", 32'h0000_0001, 32'(msg.valid));
      chk("msg_fatal", 32'(sev[unc_bits[i]]), 32'(msg.fatal));
      chk("msg_nonfatal", 32'(!sev[unc_bits[i]]), 32'(msg.nonfatal));
      chk("hdr_logged", 32'h0000_0001, 32'(hdr_logged));
      reg_chk("pointer", ERR_CTRL_OFS, 32'(unc_bits[i]));
      for (int k = 0; k < 4; k++) begin
        reg_chk("hdr_dword", 12'(HDR_LOG_OFS + 4 * k), evt.hdr[k]);
      end
      reg_wr(UNC_STATUS_OFS, bv);
    end
    // Second error while the log is held keeps the first pointer
    fire(32'h0000_4000, 32'h0000_0000);
    evt.hdr[0] <= 32'h0000_5a5a;
    fire(32'h0008_0000, 32'h0000_0000);
    exp_msgs += 2;
    chk("log_held", 32'h0000_0000, 32'(hdr_logged));
    reg_chk("pointer_held", ERR_CTRL_OFS, 32'h0000_000e);
    reg_chk("hdr_held", HDR_LOG_OFS, 32'h0a0b_0cb0);
    reg_wr(UNC_STATUS_OFS, 32'h0008_4000);
    $display("test unc_report done");
  endtask

  task automatic t_cor();
    logic [31:0] bv;
    reg_wr(COR_MASK_OFS, 32'h0000_2000);
    foreach (cor_bits[i]) begin
      bv = 32'h0000_0001 << cor_bits[i];
      fire(32'h0000_0000, bv);
      if (cor_bits[i] != 13) begin
        exp_msgs++;
      end
      chk("msg_cor", 32'(cor_bits[i] != 13), 32'(msg.cor));
      reg_wr(COR_STATUS_OFS, 32'h0000_0000);
      reg_chk("cor_status_set", COR_STATUS_OFS, bv);
      reg_wr(COR_STATUS_OFS, bv);
      reg_chk("cor_status_clr", COR_STATUS_OFS, 32'h0000_0000);
    end
    reg_wr(COR_MASK_OFS, 32'h0000_0000);
    fire(32'h0000_0000, 32'h0000_2000);
    exp_msgs++;
    chk("advisory_unmasked", 32'h0000_0001, 32'(msg.cor));
    reg_wr(COR_STATUS_OFS, 32'h0000_2000);
    // Hot reset drops the message but keeps the sticky flag
    hot_reset <= 1'b1;
    fire(32'h0000_0000, 32'h0000_0001);
    hot_reset <= 1'b0;
    chk("msg_hot", 32'h0000_0000, 32'(msg.valid));
    reg_chk("cor_status_hot", COR_STATUS_OFS, 32'h0000_0001);
    reg_wr(COR_STATUS_OFS, 32'h0000_0001);
    $display("test cor done");
  endtask

  // Power-on reset in mid-run brings every sticky bit back to its default
  task automatic t_power_on();
    reg_wr(UNC_MASK_OFS, 32'h0000_1000);
    reg_wr(UNC_SEV_OFS, 32'h0000_0000);
    fire(32'h0000_1000, 32'h0000_0000);
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    reg_chk("unc_mask_por", UNC_MASK_OFS, 32'h0000_0000);
    reg_chk("unc_sev_por", UNC_SEV_OFS, 32'h0006_2011);
    reg_chk("cor_mask_por", COR_MASK_OFS, 32'h0000_2000);
    reg_chk("unc_status_por", UNC_STATUS_OFS, 32'h0000_0000);
    $display("test power_on done");
  endtask

  // Watchdog: a hang counts as a mismatch
  initial begin
    #5_000_000;
    err_count++;
    $display("[FAIL] watchdog expected finish seen hang");
    give_verdict();
  end

  initial begin
    for (int k = 0; k < HDR_DWORDS; k++) begin
      evt.hdr[k] = 32'h0a0b_0c00 + 32'(k);
    end
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset_values();
    t_fields_sticky();
    t_unc_masked();
    t_unc_report();
    t_cor();
    repeat (2) @(posedge core_clk);
    chk("msg_count", 32'(exp_msgs), 32'(rc.n_msg));
    t_power_on();
    give_verdict();
  end
endmodule
